// File: etm_pkg.sv
// shared constants and types of the 10-bit enhanced timer
package etm_pkg;
	typedef enum logic [1:0] {ETM_CMP, ETM_CAP, ETM_PWM, ETM_TMR} etm_mode_t;
	localparam logic [7:0] OFF_TIMER_CTRL  = 8'h00;
	localparam logic [7:0] OFF_CHAN_A_CTRL = 8'h04;
	localparam logic [7:0] OFF_CHAN_B_CTRL = 8'h08;
	localparam logic [7:0] OFF_CNT_LOW     = 8'h0C;
	localparam logic [7:0] OFF_CNT_HIGH    = 8'h10;
	localparam logic [7:0] OFF_CMPA_LOW    = 8'h14;
	localparam logic [7:0] OFF_CMPA_HIGH   = 8'h18;
	localparam logic [7:0] OFF_CMPB        = 8'h1C;
	localparam int         CTRL_ON_BIT     = 3;
	localparam int         MODE_LSB        = 6;
	localparam int         FUNC_LSB        = 4;
	localparam int         INIT_BIT        = 3;
	localparam int         POL_BIT         = 2;
	localparam int         DIR_BIT         = 1;
	localparam int         CLR_BIT         = 0;
	localparam int         PERIOD_SHIFT    = 7;
	localparam logic [7:0] CTRL_RESET      = 8'h00;
	localparam logic [1:0] FUNC_00         = 2'h0;
	localparam logic [1:0] FUNC_01         = 2'h1;
	localparam logic [1:0] FUNC_10         = 2'h2;
	localparam logic [1:0] FUNC_11         = 2'h3;
endpackage : etm_pkg

// File: etm_timer.sv
// 10-bit enhanced timer: counter, comparators, pin logic, AHB-Lite registers
// Function
// - period field matches counter bits 9..7; 000 is 1024 clocks, else 128 times code.
// - period field 000 lets the counter run to 3FF and overflow.
// - channel A mode 00 compare, 01 capture, 10 PWM/pulse, 11 timer.
// - channel B mode uses the same encoding as channel A.
// - compare mode function 00 keep, 01 low, 10 high, 11 toggle on match.
// - PWM mode function 00 inactive, 01 active, 10 PWM, 11 single pulse.
// - capture function 00 rising, 01 falling, 10 both, 11 disabled.
// - initial-level bit sets compare pin level; timer-on rise restores it.
// - in PWM modes initial-level bit selects active low or active high.
// - polarity bit inverts the pin; no effect in timer mode.
// - timer mode leaves channel pins undriven.
// - read-only direction flag shows 0 up, 1 down.
// - clear-select 1 clears on compare A; 0 on period match or overflow.
// - clear-select ignored in PWM, single pulse and capture modes.
// - alignment 00 edge, 01 centre up, 10 centre down, 11 centre both.
// - counter low byte and high bits readable; high bits 7..2 read zero.
// - compare A low byte is read/write and resets to zero.
// - timer-on rise zeroes the counter; fall holds the residual count.
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module etm_timer
	import etm_pkg::*;
#(
	parameter int CNT_W = 10
)(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        timer_tick,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        chan_a_pin_in,
	output logic             chan_a_pin_out,
	output logic             chan_a_pin_oe,
	input  wire logic        chan_b_pin_in,
	output logic             chan_b_pin_out,
	output logic             chan_b_pin_oe
);
	import etm_pkg::*;

	if (CNT_W != 10)
	begin : g_bad_width
		$error("etm_timer serves a 10-bit counter only");
	end

	logic [7:0]       timer_ctrl_reg;
	logic [7:0]       chan_a_ctrl_reg;
	logic [7:0]       chan_b_ctrl_reg;
	logic [CNT_W-1:0] cmp_a_reg;
	logic [CNT_W-1:0] cmp_b_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic             dir_reg;
	logic             on_prev_reg;
	logic             wr_pend_reg;
	logic             rd_pend_reg;
	logic [7:0]       addr_reg;
	logic [1:0]       lvl_reg;
	logic [1:0]       cap_evt;

	wire              timer_on = timer_ctrl_reg[CTRL_ON_BIT];
	wire logic [2:0]  period_field = timer_ctrl_reg[2:0];
	wire              on_rise = timer_on & ~on_prev_reg;
	wire              run_tick = timer_on & on_prev_reg & timer_tick;
	wire etm_mode_t   mode_a = etm_mode_t'(chan_a_ctrl_reg[MODE_LSB +: 2]);
	wire etm_mode_t   mode_b = etm_mode_t'(chan_b_ctrl_reg[MODE_LSB +: 2]);
	wire logic [1:0]  align = chan_b_ctrl_reg[1:0];
	wire              clear_select = chan_a_ctrl_reg[CLR_BIT];
	wire              centre = (mode_a == ETM_PWM) && (align != 2'h0);
	// clear-select only counts in compare and timer modes
	wire              use_a_clear = clear_select && (mode_a == ETM_CMP || mode_a == ETM_TMR);
	wire logic [CNT_W-1:0] cnt_inc = cnt_reg + 10'h001;
	wire              match_a = (cnt_reg == cmp_a_reg);
	// compare on the incremented value so a code of n gives exactly 128*n clocks
	wire              period_hit = (period_field != 3'h0)
		&& (cnt_inc[CNT_W-1:PERIOD_SHIFT] == period_field);
	wire              clear_hit = use_a_clear ? match_a : period_hit;
	wire logic [CNT_W-1:0] top = (period_field == 3'h0) ? 10'h3FF
		: ({period_field, 7'h00} - 10'h001);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			on_prev_reg <= 1'b0;
		else
			on_prev_reg <= timer_on;
	end

	always_comb
	begin
		cnt_next = cnt_inc;
		if (centre)
		begin
			if (!dir_reg && cnt_reg == top)
				cnt_next = cnt_reg - 10'h001;
			else if (dir_reg && cnt_reg == 10'h000)
				cnt_next = 10'h001;
			else if (dir_reg)
				cnt_next = cnt_reg - 10'h001;
		end
		else if (clear_hit)
			cnt_next = 10'h000;
	end

	// counter holds while off; a 3FF wrap is the overflow clear
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_reg <= 10'h000;
			dir_reg <= 1'b0;
		end
		else if (on_rise)
		begin
			cnt_reg <= 10'h000;
			dir_reg <= 1'b0;
		end
		else if (run_tick)
		begin
			cnt_reg <= cnt_next;
			if (centre && !dir_reg && cnt_reg == top)
				dir_reg <= 1'b1;
			else if (!centre || cnt_reg == 10'h000)
				dir_reg <= 1'b0;
		end
	end

	genvar i;
	generate
		for (i = 0; i < 2; i++)
		begin : g_chan
			logic [7:0]       ctrl;
			logic [CNT_W-1:0] cmp;
			logic             pin_in;
			logic [2:0]       sync_reg;
			logic             out_reg;
			logic             oe_reg;
			etm_mode_t        mode;
			logic [1:0]       func;
			logic             hit;
			logic             dir_ok;
			logic             raw;
			assign ctrl = (i == 0) ? chan_a_ctrl_reg : chan_b_ctrl_reg;
			assign cmp = (i == 0) ? cmp_a_reg : cmp_b_reg;
			assign pin_in = (i == 0) ? chan_a_pin_in : chan_b_pin_in;
			assign mode = etm_mode_t'(ctrl[MODE_LSB +: 2]);
			assign func = ctrl[FUNC_LSB +: 2];
			assign dir_ok = !centre || (dir_reg ? align[1] : align[0]);
			assign hit = run_tick && (cnt_reg == cmp) && dir_ok;

			// only sync_reg[1] and later stages feed the edge detector
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					sync_reg <= 3'h0;
				else
					sync_reg <= {sync_reg[1:0], pin_in};
			end

			always_comb
			begin
				cap_evt[i] = 1'b0;
				if (mode == ETM_CAP && timer_on)
				begin
					case (func)
						FUNC_00: cap_evt[i] = sync_reg[1] & ~sync_reg[2];
						FUNC_01: cap_evt[i] = ~sync_reg[1] & sync_reg[2];
						FUNC_10: cap_evt[i] = sync_reg[1] ^ sync_reg[2];
						default: cap_evt[i] = 1'b0;
					endcase
				end
			end

			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					lvl_reg[i] <= 1'b0;
				else if (mode == ETM_CMP)
				begin
					if (on_rise)
						lvl_reg[i] <= ctrl[INIT_BIT];
					else if (hit)
					begin
						case (func)
							FUNC_01: lvl_reg[i] <= 1'b0;
							FUNC_10: lvl_reg[i] <= 1'b1;
							FUNC_11: lvl_reg[i] <= ~lvl_reg[i];
							default: lvl_reg[i] <= lvl_reg[i];
						endcase
					end
				end
				else if (mode == ETM_PWM)
				begin
					case (func)
						FUNC_00: lvl_reg[i] <= 1'b0;
						FUNC_01: lvl_reg[i] <= 1'b1;
						FUNC_10:
						begin
							if (on_rise)
								lvl_reg[i] <= (cmp != 10'h000);
							else if (hit)
								lvl_reg[i] <= centre && dir_reg;
							else if (run_tick && !centre && cnt_next == 10'h000)
								lvl_reg[i] <= (cmp != 10'h000);
						end
						default:
						begin
							if (on_rise)
								lvl_reg[i] <= 1'b1;
							else if (hit)
								lvl_reg[i] <= 1'b0;
						end
					endcase
				end
			end

			// PWM level is active high or low per the initial-level bit
			assign raw = (mode == ETM_PWM) ? ~(lvl_reg[i] ^ ctrl[INIT_BIT]) : lvl_reg[i];

			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					out_reg <= 1'b0;
					oe_reg <= 1'b0;
				end
				else
				begin
					out_reg <= raw ^ ctrl[POL_BIT];
					oe_reg <= (mode == ETM_CMP) || (mode == ETM_PWM);
				end
			end
		end
	endgenerate

	assign chan_a_pin_out = g_chan[0].out_reg;
	assign chan_a_pin_oe = g_chan[0].oe_reg;
	assign chan_b_pin_out = g_chan[1].out_reg;
	assign chan_b_pin_oe = g_chan[1].oe_reg;

	// bus: writes complete zero-wait, reads take one wait state so data is fresh
	wire addr_ok = hsel && htrans[1] && hready;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			addr_reg <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			wr_pend_reg <= addr_ok && hwrite;
			rd_pend_reg <= addr_ok && !hwrite;
			hreadyout <= !(addr_ok && !hwrite);
			if (addr_ok)
				addr_reg <= haddr[7:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			timer_ctrl_reg <= CTRL_RESET;
			chan_a_ctrl_reg <= CTRL_RESET;
			chan_b_ctrl_reg <= CTRL_RESET;
		end
		else if (wr_pend_reg)
		begin
			case (addr_reg)
				OFF_TIMER_CTRL: timer_ctrl_reg <= {4'h0, hwdata[3:0]};
				OFF_CHAN_A_CTRL: chan_a_ctrl_reg <= {hwdata[7:2], 1'b0, hwdata[0]};
				OFF_CHAN_B_CTRL: chan_b_ctrl_reg <= hwdata[7:0];
				default: timer_ctrl_reg <= timer_ctrl_reg;
			endcase
		end
	end

	// a capture in the same cycle as a software write wins
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmp_a_reg <= 10'h000;
			cmp_b_reg <= 10'h000;
		end
		else
		begin
			if (cap_evt[0])
				cmp_a_reg <= cnt_reg;
			else if (wr_pend_reg && addr_reg == OFF_CMPA_LOW)
				cmp_a_reg[7:0] <= hwdata[7:0];
			else if (wr_pend_reg && addr_reg == OFF_CMPA_HIGH)
				cmp_a_reg[9:8] <= hwdata[1:0];
			if (cap_evt[1])
				cmp_b_reg <= cnt_reg;
			else if (wr_pend_reg && addr_reg == OFF_CMPB)
				cmp_b_reg <= hwdata[9:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			hrdata <= 32'h0000_0000;
		else if (rd_pend_reg)
		begin
			case (addr_reg)
				OFF_TIMER_CTRL: hrdata <= {24'h0, timer_ctrl_reg};
				OFF_CHAN_A_CTRL: hrdata <= {24'h0, chan_a_ctrl_reg[7:2], dir_reg,
					chan_a_ctrl_reg[0]};
				OFF_CHAN_B_CTRL: hrdata <= {24'h0, chan_b_ctrl_reg};
				OFF_CNT_LOW: hrdata <= {24'h0, cnt_reg[7:0]};
				OFF_CNT_HIGH: hrdata <= {30'h0, cnt_reg[9:8]};
				OFF_CMPA_LOW: hrdata <= {24'h0, cmp_a_reg[7:0]};
				OFF_CMPA_HIGH: hrdata <= {30'h0, cmp_a_reg[9:8]};
				OFF_CMPB: hrdata <= {22'h0, cmp_b_reg};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	property p_period_clear;
		@(posedge clk) disable iff (!rst_n)
		(run_tick && !centre && !use_a_clear && period_field != 3'h0
			&& cnt_reg == {period_field, 7'h00} - 10'h001) |=> (cnt_reg == 10'h000);
	endproperty
	a_period_clear: assert property (p_period_clear) else $error("no period clear");

	property p_overflow;
		@(posedge clk) disable iff (!rst_n)
		(run_tick && !centre && !use_a_clear && period_field == 3'h0 && cnt_reg == 10'h3FF)
			|=> (cnt_reg == 10'h000);
	endproperty
	a_overflow: assert property (p_overflow) else $error("no overflow wrap");

	property p_a_clear;
		@(posedge clk) disable iff (!rst_n)
		(run_tick && use_a_clear && !centre && match_a) |=> (cnt_reg == 10'h000);
	endproperty
	a_a_clear: assert property (p_a_clear) else $error("no compare A clear");

	property p_hold_off;
		@(posedge clk) disable iff (!rst_n)
		(!timer_on && !on_prev_reg) |=> $stable(cnt_reg);
	endproperty
	a_hold_off: assert property (p_hold_off) else $error("counter moved while off");

	property p_init_level;
		@(posedge clk) disable iff (!rst_n)
		(on_rise && mode_a == ETM_CMP) |=> (lvl_reg[0] == $past(chan_a_ctrl_reg[INIT_BIT]))
			##1 (chan_a_pin_out == ($past(lvl_reg[0]) ^ $past(chan_a_ctrl_reg[POL_BIT])));
	endproperty
	a_init_level: assert property (p_init_level) else $error("initial level lost");

	property p_toggle;
		@(posedge clk) disable iff (!rst_n)
		(mode_a == ETM_CMP && !on_rise && g_chan[0].hit && g_chan[0].func == FUNC_11)
			|=> (lvl_reg[0] != $past(lvl_reg[0]));
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle missed");

	property p_timer_undriven;
		@(posedge clk) disable iff (!rst_n)
		(mode_a == ETM_TMR) [*2] |-> !chan_a_pin_oe;
	endproperty
	a_timer_undriven: assert property (p_timer_undriven) else $error("pin driven");

	property p_read_high;
		@(posedge clk) disable iff (!rst_n)
		(rd_pend_reg && addr_reg == OFF_CNT_HIGH) |=> (hreadyout && hrdata[31:2] == 30'h0
			&& hrdata[1:0] == $past(cnt_reg[9:8]));
	endproperty
	a_read_high: assert property (p_read_high) else $error("bad counter high read");

endmodule : etm_timer
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the enhanced timer registers, counter and channel pins
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import etm_pkg::*;
	logic        clk, rst_n, timer_tick, hsel, hwrite, hready, hreadyout, hresp;
	logic        a_in, a_out, a_oe, b_in, b_out, b_oe, ini, pol, ex;
	logic [1:0]  htrans, f;
	logic [2:0]  hsize;
	logic [7:0]  ctl;
	logic [31:0] haddr, hwdata, hrdata, rd;
	int          miscompares, total_checks, i;
	assign hready = hreadyout;
	etm_timer dut (.clk(clk), .rst_n(rst_n), .timer_tick(timer_tick), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.chan_a_pin_in(a_in), .chan_a_pin_out(a_out), .chan_a_pin_oe(a_oe),
		.chan_b_pin_in(b_in), .chan_b_pin_out(b_out), .chan_b_pin_oe(b_oe));
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task give_verdict;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict
	// address phase held until hready, then data phase held until hready again
	task ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
		chk("response", {31'h0, hresp}, 32'h0);
	endtask : ahb
	task rdc(input logic [7:0] a, input logic [31:0] exp);
		ahb(a, 1'b0, 32'h0);
		chk($sformatf("register %h", a), rd, exp);
	endtask : rdc
	// mode and function fields only change while the timer is off
	task cfg(input logic [7:0] ca, input logic [7:0] cb, input logic [2:0] per);
		ahb(OFF_TIMER_CTRL, 1'b1, {29'h0, per});
		ahb(OFF_CHAN_A_CTRL, 1'b1, {24'h0, ca});
		ahb(OFF_CHAN_B_CTRL, 1'b1, {24'h0, cb});
		ahb(OFF_TIMER_CTRL, 1'b1, {28'h0, 1'b1, per});
	endtask : cfg
	// ticks spaced one idle cycle apart; settle margin covers the pin lag
	task tick(input int n);
		repeat (2) @(posedge clk);
		repeat (n)
		begin
			timer_tick <= 1'b1;
			@(posedge clk);
			timer_tick <= 1'b0;
			@(posedge clk);
		end
		repeat (4) @(posedge clk);
	endtask : tick
	task pin_chk(input logic ea, input logic eb, input logic eoe);
		chk("pin a level", {31'h0, a_out}, {31'h0, ea});
		chk("pin b level", {31'h0, b_out}, {31'h0, eb});
		chk("pin a enable", {31'h0, a_oe}, {31'h0, eoe});
		chk("pin b enable", {31'h0, b_oe}, {31'h0, eoe});
	endtask : pin_chk
	initial
	begin
		repeat (20000) @(posedge clk);
		miscompares++;
		give_verdict();
	end
	initial
	begin
		rst_n = 1'b0;
		timer_tick = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		a_in = 1'b0;
		b_in = 1'b0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rdc(OFF_CHAN_A_CTRL, 32'h0);
		rdc(OFF_CHAN_B_CTRL, 32'h0);
		rdc(OFF_CNT_LOW, 32'h0);
		rdc(OFF_CNT_HIGH, 32'h0);
		rdc(OFF_CMPA_LOW, 32'h0);
		ahb(OFF_CHAN_A_CTRL, 1'b1, 32'hFF);
		rdc(OFF_CHAN_A_CTRL, 32'hFD);
		ahb(OFF_CHAN_B_CTRL, 1'b1, 32'hFF);
		rdc(OFF_CHAN_B_CTRL, 32'hFF);
		ahb(OFF_CMPA_LOW, 1'b1, 32'h1A5);
		rdc(OFF_CMPA_LOW, 32'hA5);
		ahb(OFF_CNT_LOW, 1'b1, 32'h55);
		rdc(OFF_CNT_LOW, 32'h0);
		rdc(8'h40, 32'h0);
		$display("test registers done");
		cfg(8'h00, 8'h00, 3'h1);
		tick(130);
		rdc(OFF_CNT_LOW, 32'h02);
		cfg(8'h00, 8'h00, 3'h0);
		tick(757);
		rdc(OFF_CNT_LOW, 32'hF5);
		rdc(OFF_CNT_HIGH, 32'h2);
		rdc(OFF_CHAN_A_CTRL, 32'h0);
		ahb(OFF_TIMER_CTRL, 1'b1, 32'h0);
		tick(3);
		rdc(OFF_CNT_LOW, 32'hF5);
		ahb(OFF_TIMER_CTRL, 1'b1, 32'h8);
		tick(0);
		rdc(OFF_CNT_LOW, 32'h0);
		tick(1030);
		rdc(OFF_CNT_LOW, 32'h06);
		rdc(OFF_CNT_HIGH, 32'h0);
		$display("test counter done");
		ahb(OFF_CMPA_LOW, 1'b1, 32'h3);
		ahb(OFF_CMPA_HIGH, 1'b1, 32'h0);
		ahb(OFF_CMPB, 1'b1, 32'h3);
		cfg(8'h01, 8'h00, 3'h0);
		tick(10);
		rdc(OFF_CNT_LOW, 32'h02);
		cfg(8'h81, 8'h80, 3'h0);
		tick(10);
		rdc(OFF_CNT_LOW, 32'h0A);
		for (i = 0; i < 16; i++)
		begin
			f = i[1:0];
			ini = (f == FUNC_01 || f == FUNC_10) ? f[0] : i[2];
			pol = i[3];
			ctl = {2'b00, f, ini, pol, 2'b00};
			cfg(ctl, ctl, 3'h0);
			tick(0);
			pin_chk(ini ^ pol, ini ^ pol, 1'b1);
			tick(5);
			ex = (f == FUNC_00) ? ini : (f == FUNC_01) ? 1'b0 : (f == FUNC_10) ? 1'b1 : ~ini;
			pin_chk(ex ^ pol, ex ^ pol, 1'b1);
		end
		$display("test compare output done");
		for (i = 0; i < 4; i++)
		begin
			ini = i[1];
			ctl = {2'b10, 1'b0, i[0], ini, 3'b000};
			cfg(ctl, ctl, 3'h0);
			tick(2);
			ex = i[0] ? ini : ~ini;
			pin_chk(ex, ex, 1'b1);
		end
		for (i = 0; i < 2; i++)
		begin
			ctl = i[0] ? 8'hB8 : 8'hA8;
			cfg(ctl, ctl, 3'h0);
			tick(1);
			pin_chk(1'b1, 1'b1, 1'b1);
			tick(4);
			pin_chk(1'b0, 1'b0, 1'b1);
		end
		cfg(8'hA8, 8'hAB, 3'h1);
		tick(5);
		pin_chk(1'b0, 1'b0, 1'b1);
		tick(130);
		rdc(OFF_CHAN_A_CTRL, 32'hAA);
		rdc(OFF_CNT_LOW, 32'h77);
		pin_chk(1'b0, 1'b0, 1'b1);
		tick(117);
		pin_chk(1'b1, 1'b1, 1'b1);
		rdc(OFF_CNT_LOW, 32'h02);
		cfg(8'hC0, 8'hC0, 3'h0);
		tick(2);
		chk("pin a enable", {31'h0, a_oe}, 32'h0);
		chk("pin b enable", {31'h0, b_oe}, 32'h0);
		$display("test pwm and timer mode done");
		cfg(8'h40, 8'h40, 3'h0);
		tick(9);
		a_in <= 1'b1;
		b_in <= 1'b1;
		tick(0);
		rdc(OFF_CMPA_LOW, 32'h09);
		rdc(OFF_CMPB, 32'h09);
		cfg(8'h70, 8'h70, 3'h0);
		tick(4);
		a_in <= 1'b0;
		b_in <= 1'b0;
		tick(2);
		a_in <= 1'b1;
		b_in <= 1'b1;
		tick(0);
		rdc(OFF_CMPA_LOW, 32'h09);
		rdc(OFF_CMPB, 32'h09);
		cfg(8'h50, 8'h50, 3'h0);
		tick(5);
		a_in <= 1'b0;
		b_in <= 1'b0;
		tick(0);
		rdc(OFF_CMPA_LOW, 32'h05);
		rdc(OFF_CMPB, 32'h05);
		cfg(8'h60, 8'h60, 3'h0);
		tick(7);
		a_in <= 1'b1;
		b_in <= 1'b1;
		tick(0);
		rdc(OFF_CMPA_LOW, 32'h07);
		rdc(OFF_CMPB, 32'h07);
		$display("test capture done");
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
